// ==== exf_source.sv ====
// far-end source model: bit clock and word clock of a filter/stream source
// assumes the bench changes run, dsd and perWord between checks only
`timescale 1ns/1ns
`default_nettype none

module exf_source (
    input  wire logic       run,        // bit clock running
    input  wire logic       dsd,        // stream mode selected
    input  wire logic [9:0] perWord,    // bit clocks per word cycle
    output logic            bitClock,   // link bit clock
    output logic            wordClockIn // word clock
);
    int n = 0;

    // odd start offset keeps the link clock out of phase with clk
    initial begin
        bitClock = 1'b0;
        #7;
        forever #16 bitClock = run & ~bitClock;
    end

    // stream mode holds the word clock low
    always @(posedge bitClock) begin
        n = (n + 1 >= int'(perWord)) ? 0 : n + 1;
        wordClockIn <= !dsd && (n < int'(perWord) / 2);
    end
endmodule : exf_source
`default_nettype wire

// ==== mode_detect_mute.sv ====
// external-filter / one-bit stream mode detection with soft mute,
// zero-data flags, fullscale auto mute and internal reset on mode change
// assumes control bits and samples are synchronous to clk; soft mute pin
// and word clock are asynchronous; the bit clock is the link clock
//
// Functional notes
// - enter stream mode once over 256 bit-clock edges in one word cycle
// - enter word mode after two consecutive word cycles with at most 256
// - otherwise keep the current mode unchanged
// - detection runs on the bit clock, even without master clock
// - master clock gone: outputs float; on return resume detected mode (here analogFloat is set only by reset and powerEnableBits == 2'b00)
// - a stopped bit clock holds the last detected mode
// - every mode change gives an internal reset of 3 to 4 samples
// - detection starts after auto enable while soft reset is still held
// - word-to-stream takes 256 bit clocks, back takes two word cycles
// - nonzero data stops detection; zero wait restarts it
// - auto detect in filter mode adds 18 samples of latency
// - stream stopped: stay in mode; fullscale auto mute when enabled
// - mute request ramps level down to full mute step by step
// - mute release ramps level back up to the programmed value
// - early release climbs back by the steps already taken
// - stream mode with volume bypass applies no soft mute
// - zero flag after 8192 zero samples, 16384 at top rate; nonzero clears
// - zero wait select: 8192, 4096, 2048, 1024 samples plus 18
// - detected mode flag reads 0 for word mode, 1 for stream mode
`timescale 1ns/1ns
`default_nettype none

module mode_detect_mute
    import mode_detect_pkg::*;
#(
    parameter int          DW          = 32,
    parameter logic [14:0] ZERO_RUN    = ZERO_RUN_DEF,
    parameter logic [14:0] ZERO_RUN_HI = ZERO_RUN_HI_DEF,
    parameter logic [14:0] WAIT_BASE   = WAIT_BASE_DEF
)(
    input  wire logic          clk,                  // master clock
    input  wire logic          reset_n,              // sync reset, low
    input  wire logic          bitClock,             // link bit clock
    input  wire logic          wordClockIn,          // word clock pin
    input  wire logic          externalFilterSelect, // filter input chosen
    input  wire logic          autoDetectEnable,     // auto switching on
    input  wire logic          softResetRelease,     // 0 holds soft reset
    input  wire logic [1:0]    powerEnableBits,      // channel power bits
    input  wire logic [1:0]    zeroWaitSelect,       // restart wait code
    input  wire logic          fullscaleAutoMute,    // mute on fullscale
    input  wire logic          fullscaleDetectTime,  // fullscale run length
    input  wire logic          dsdHighestRate,       // top stream rate
    input  wire logic          softMutePin,          // async mute pin
    input  wire logic          softMuteBit,          // mute control bit
    input  wire logic          volumeBypass,         // stream volume bypass
    input  wire logic [7:0]    attenuationValue,     // programmed level
    input  wire logic [7:0]    attenuationStepTime,  // samples per step
    input  wire logic          sampleStrobe,         // one pulse per sample
    input  wire logic [DW-1:0] leftSample,           // left input word
    input  wire logic [DW-1:0] rightSample,          // right input word
    output logic               detectedModeFlag,     // 1 = stream mode
    output logic               detectActive,         // detection running
    output logic               internalReset,        // mode-change reset
    output logic               analogFloat,          // outputs floating
    output logic [1:0]         zeroDetectOutputs,    // {right, left}
    output logic [7:0]         rampLevel,            // current mute level
    output logic               outValid,             // output word strobe
    output logic [DW-1:0]      leftOut,              // left output word
    output logic [DW-1:0]      rightOut              // right output word
);

    typedef struct packed {
        logic [2:0]                              modeSync;
        logic [1:0]                              muteSync;
        logic                                    detectEnable;
        logic [1:0][RUN_W-1:0]                   zeroCnt;
        logic [1:0]                              zeroFlag;
        logic [RUN_W-1:0]                        waitCnt;
        logic                                    waitDone;
        logic [RUN_W-1:0]                        fsCnt;
        logic                                    fsMute;
        logic [2:0]                              rstCnt;
        logic                                    intRst;
        logic [7:0]                              level;
        logic [7:0]                              stepCnt;
        logic [LATENCY_SAMPLES-1:0][DW-1:0]      dlyL;
        logic [LATENCY_SAMPLES-1:0][DW-1:0]      dlyR;
        logic [DW-1:0]                           outL;
        logic [DW-1:0]                           outR;
        logic                                    outValid;
        logic                                    modeFlag;
        logic                                    analogFloat;
    } core_t;

    core_t r;
    core_t n;
    logic  modeDsdLink;
    logic  muteReq;
    logic  bypass;
    logic  stepTick;
    logic  bothZero;
    logic  bothFull;
    logic  delayPath;
    logic [RUN_W-1:0] zeroThr;
    logic [RUN_W-1:0] fsThr;
    logic [DW-1:0]    selL;
    logic [DW-1:0]    selR;

    function automatic logic isFullScale(input logic [DW-1:0] s);
        // either signed extreme counts as a stalled stream
        return (s == {1'b0, {(DW-1){1'b1}}}) || (s == {1'b1, {(DW-1){1'b0}}});
    endfunction : isFullScale

    function automatic logic [RUN_W-1:0] waitSamples(input logic [1:0] sel);
        return RUN_W'((WAIT_BASE >> sel) + WAIT_PAD);
    endfunction : waitSamples

    wck_bck_detector u_detector (
        .bitClock     (bitClock),
        .reset_n      (reset_n),
        .wordClockIn  (wordClockIn),
        .detectEnable (r.detectEnable),
        .modeDsd      (modeDsdLink)
    );

    assign muteReq   = r.muteSync[1] | softMuteBit
                     | (fullscaleAutoMute & r.fsMute);
    assign bypass    = r.modeSync[1] & volumeBypass;
    assign stepTick  = sampleStrobe &&
                       (8'(r.stepCnt + 8'h01) >= attenuationStepTime);
    // output silenced by mute counts as zero data for the restart wait
    assign bothZero  = ((leftSample == '0) && (rightSample == '0))
                     || (r.level == 8'h00);
    assign bothFull  = isFullScale(leftSample) && isFullScale(rightSample);
    assign zeroThr   = dsdHighestRate ? ZERO_RUN_HI : ZERO_RUN;
    assign fsThr     = fullscaleDetectTime ? FS_RUN_LONG : FS_RUN_SHORT;
    assign delayPath = autoDetectEnable && externalFilterSelect
                     && !r.modeSync[1];
    assign selL = delayPath ? r.dlyL[LATENCY_SAMPLES-1] : leftSample;
    assign selR = delayPath ? r.dlyR[LATENCY_SAMPLES-1] : rightSample;

    always_comb begin
        n = r;
        // mode crosses from the bit-clock domain as a level
        n.modeSync = {r.modeSync[1:0], modeDsdLink};
        n.muteSync = {r.muteSync[0], softMutePin};
        n.modeFlag = r.modeSync[1];
        n.analogFloat = (powerEnableBits == 2'b00);
        n.outValid = sampleStrobe;

        if (sampleStrobe) begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0 ? leftSample : rightSample) != '0) begin
                    n.zeroCnt[i]  = '0;
                    n.zeroFlag[i] = 1'b0;
                end else begin
                    if (r.zeroCnt[i] < zeroThr) begin
                        n.zeroCnt[i] = RUN_W'(r.zeroCnt[i] + 1'b1);
                    end
                    n.zeroFlag[i] =
                        (RUN_W'(r.zeroCnt[i] + 1'b1) >= zeroThr);
                end
            end
            if (!bothZero) begin
                n.waitCnt  = '0;
                n.waitDone = 1'b0;
            end else begin
                if (r.waitCnt < waitSamples(zeroWaitSelect)) begin
                    n.waitCnt = RUN_W'(r.waitCnt + 1'b1);
                end
                n.waitDone = (RUN_W'(r.waitCnt + 1'b1)
                              >= waitSamples(zeroWaitSelect));
            end
            // stream stalled at fullscale: mode is kept, output muted if fullscaleAutoMute
            if (!(r.modeSync[1] && bothFull)) begin
                n.fsCnt  = '0;
                n.fsMute = 1'b0;
            end else begin
                if (r.fsCnt < fsThr) begin
                    n.fsCnt = RUN_W'(r.fsCnt + 1'b1);
                end
                n.fsMute = (RUN_W'(r.fsCnt + 1'b1) >= fsThr);
            end
        end

        // filter select must already be set when auto enable arrives
        n.detectEnable = autoDetectEnable && externalFilterSelect
                       && (n.waitDone || n.fsMute
                           || powerEnableBits == 2'b00
                           || !softResetRelease);

        if (r.modeSync[1] != r.modeSync[2]) begin
            n.intRst = 1'b1;
            n.rstCnt = 3'h0;
        end else if (r.intRst && sampleStrobe) begin
            n.rstCnt = 3'(r.rstCnt + 3'h1);
            // fourth strobe ends it: 3 to 4 sample periods long
            if (r.rstCnt == RESET_LAST) begin
                n.intRst = 1'b0;
            end
        end

        if (sampleStrobe) begin
            n.stepCnt = stepTick ? 8'h00 : 8'(r.stepCnt + 8'h01);
        end
        if (bypass) begin
            n.level = attenuationValue;
        end else if (stepTick) begin
            if (muteReq) begin
                if (r.level != 8'h00) begin
                    n.level = 8'(r.level - 8'h01);
                end
            end else if (r.level < attenuationValue) begin
                // one step up per step down taken: same duration back
                n.level = 8'(r.level + 8'h01);
            end else begin
                n.level = attenuationValue;
            end
        end

        if (sampleStrobe) begin
            n.dlyL = {r.dlyL[LATENCY_SAMPLES-2:0], leftSample};
            n.dlyR = {r.dlyR[LATENCY_SAMPLES-2:0], rightSample};
            if (r.intRst || n.level == 8'h00) begin
                n.outL = '0;
                n.outR = '0;
            end else begin
                n.outL = selL;
                n.outR = selR;
            end
        end

        if (!reset_n) begin
            n.modeSync     = {3{MODE_RESET}};
            n.muteSync     = 2'b00;
            n.detectEnable = 1'b0;
            n.zeroCnt      = '0;
            n.zeroFlag     = 2'b00;
            n.waitCnt      = '0;
            n.waitDone     = 1'b0;
            n.fsCnt        = '0;
            n.fsMute       = 1'b0;
            n.rstCnt       = 3'h0;
            n.intRst       = 1'b0;
            n.level        = LEVEL_RESET;
            n.stepCnt      = 8'h00;
            n.dlyL         = '0;
            n.dlyR         = '0;
            n.outL         = '0;
            n.outR         = '0;
            n.outValid     = 1'b0;
            n.modeFlag     = MODE_RESET;
            n.analogFloat  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        r <= n;
    end

    assign detectedModeFlag  = r.modeFlag;
    assign detectActive      = r.detectEnable;
    assign internalReset     = r.intRst;
    assign analogFloat       = r.analogFloat;
    assign zeroDetectOutputs = r.zeroFlag;
    assign rampLevel         = r.level;
    assign outValid          = r.outValid;
    assign leftOut           = r.outL;
    assign rightOut          = r.outR;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_reset_on_change: assert property (
        (r.modeSync[1] != r.modeSync[2]) |=> r.intRst)
        else $error("no internal reset after mode change");

    a_reset_length: assert property (
        $fell(r.intRst) |-> ($past(r.rstCnt) == RESET_LAST)
                            && $past(sampleStrobe))
        else $error("internal reset ended after wrong strobe count");

    a_zero_flag_clear: assert property (
        (sampleStrobe && leftSample != '0) |=> !zeroDetectOutputs[0])
        else $error("left zero flag not cleared by nonzero sample");

    a_detect_stop: assert property (
        (sampleStrobe && leftSample != '0 && r.level != 8'h00
         && !r.modeSync[1] && powerEnableBits != 2'b00
         && softResetRelease) |=> !detectActive)
        else $error("detection kept running on nonzero data");

    a_ramp_down: assert property (
        (!bypass && muteReq && stepTick && r.level != 8'h00)
        |=> r.level == $past(r.level) - 8'h01)
        else $error("mute ramp did not step down");

    a_ramp_up: assert property (
        (!bypass && !muteReq && stepTick && r.level < attenuationValue)
        |=> r.level == $past(r.level) + 8'h01)
        else $error("release ramp did not step up");

    a_bypass_no_mute: assert property (
        bypass |=> r.level == $past(attenuationValue))
        else $error("soft mute applied under volume bypass");

    a_mode_flag_sync: assert property (
        $changed(r.modeSync[1]) |=> detectedModeFlag == $past(r.modeSync[1]))
        else $error("mode flag does not follow synchronised mode");

endmodule : mode_detect_mute

`default_nettype wire

// ==== mode_detect_pkg.sv ====
// constants shared by the word/bit-clock mode detector and the mute core
// assumes counts in sample periods are taken from a one-cycle sample strobe
package mode_detect_pkg;

    // bit-clock edge count per word-clock cycle, and short word cycles needed for word mode
    localparam logic [8:0]  WCK_EDGE_LIMIT  = 9'h100;
    localparam logic [8:0]  WCK_EDGE_SAT    = 9'h101;
    localparam logic [1:0]  EXF_SHORT_RUNS  = 2'h2;

    // internal reset after a mode change, in sample strobes (last index)
    localparam logic [2:0]  RESET_LAST      = 3'h3;

    // extra path latency with auto detection, in sample periods
    localparam int          LATENCY_SAMPLES = 18;

    // counter width in bits, run lengths in sample periods
    localparam int          RUN_W           = 15;
    localparam logic [14:0] WAIT_PAD        = 15'h0012;
    localparam logic [14:0] WAIT_BASE_DEF   = 15'h2000;
    localparam logic [14:0] ZERO_RUN_DEF    = 15'h2000;
    localparam logic [14:0] ZERO_RUN_HI_DEF = 15'h4000;
    localparam logic [14:0] FS_RUN_SHORT    = 15'h0400;
    localparam logic [14:0] FS_RUN_LONG     = 15'h0800;

    // reset values
    localparam logic [7:0]  LEVEL_RESET     = 8'h00;
    localparam logic        MODE_RESET      = 1'b0;

endpackage : mode_detect_pkg

// ==== test_mode_detect_mute.sv ====
// bench for the mode detector and mute core with a far-end clock source
// assumes short run-length parameters and a sample strobe every 4 clocks
`timescale 1ns/1ns
`default_nettype none

module test_mode_detect_mute;
    logic        clk = 1'b0, reset_n = 1'b0, run = 1'b1, dsd = 1'b0;
    logic        bitClock, wordClockIn, sampleStrobe = 1'b0;
    logic        externalFilterSelect = 1'b0, autoDetectEnable = 1'b0;
    logic        softResetRelease = 1'b0, softMutePin = 1'b0;
    logic        softMuteBit = 1'b0, volumeBypass = 1'b0;
    logic [1:0]  powerEnableBits = 2'h0, zeroWaitSelect = 2'h3;
    logic [7:0]  attenuationValue = 8'h06, attenuationStepTime = 8'h01;
    logic [31:0] leftSample = 32'h0, rightSample = 32'h0;
    logic        fullscaleAutoMute = 1'b0, outValid;
    logic [31:0] leftOut, rightOut;
    logic [9:0]  perWord = 10'h080;
    logic        detectedModeFlag, detectActive, internalReset, analogFloat;
    logic [1:0]  zeroDetectOutputs;
    logic [7:0]  rampLevel;
    int          n_fail = 0, samples_checked = 0, ph = 0;

    mode_detect_mute #(
        .DW(32), .ZERO_RUN(15'h0010), .ZERO_RUN_HI(15'h0020),
        .WAIT_BASE(15'h0010)
    ) uut (
        .clk, .reset_n, .bitClock, .wordClockIn, .externalFilterSelect,
        .autoDetectEnable, .softResetRelease, .powerEnableBits,
        .zeroWaitSelect, .fullscaleAutoMute,
        .fullscaleDetectTime(1'b0), .dsdHighestRate(1'b0), .softMutePin,
        .softMuteBit, .volumeBypass, .attenuationValue,
        .attenuationStepTime, .sampleStrobe, .leftSample, .rightSample,
        .detectedModeFlag, .detectActive, .internalReset, .analogFloat,
        .zeroDetectOutputs, .rampLevel, .outValid, .leftOut,
        .rightOut
    );
    exf_source src (.run, .dsd, .perWord, .bitClock, .wordClockIn);

    always #25 clk = ~clk;

    always @(posedge clk) begin
        ph <= (ph + 1) % 4;
        sampleStrobe <= #2 (ph == 0);
    end

    task automatic conclude();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %0h, wanted %0h", $time, seen, exp);
        end
    endtask : check

    // sel: 0 mode flag, 1 internal reset, 2 ramp level, 3 detect active
    task automatic wait_for(input int sel, input logic [7:0] v, input int lim);
        logic [7:0] s;
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            #2;
            s = sel == 0 ? 8'(detectedModeFlag) : sel == 1 ?
                8'(internalReset) : sel == 2 ? rampLevel : 8'(detectActive);
            if (s === v) begin
                samples_checked++;
                return;
            end
        end
        n_fail++;
        $display("Error at %0t: wait %0d timed out", $time, sel);
        conclude();
    endtask : wait_for

    task automatic strobes(input int n);
        repeat (n) @(posedge clk iff sampleStrobe);
        #2;
    endtask : strobes

    initial begin
        int k;
        int m;
        repeat (2) @(posedge clk);
        #2 reset_n = 1'b1;
        check(detectedModeFlag, 0);
        check(analogFloat, 1);
        externalFilterSelect = 1'b1;
        @(posedge clk);
        #2 autoDetectEnable = 1'b1;
        repeat (200) @(posedge clk);
        #2 check(detectedModeFlag, 0);
        check(detectActive, 1);
        dsd = 1'b1;
        repeat (60) @(posedge clk);
        #2 check(detectedModeFlag, 0);
        wait_for(0, 8'h01, 400);
        check(internalReset, 1);
        k = 0;
        m = 0;
        while (internalReset === 1'b1 && k < 100) begin
            @(posedge clk);
            if (sampleStrobe) m++;
            k++;
            #2;
        end
        check(32'(m >= 3 && m <= 4), 1);
        run = 1'b0;
        repeat (200) @(posedge clk);
        #2 check(detectedModeFlag, 1);
        fullscaleAutoMute = 1'b1;
        leftSample = 32'h7FFF_FFFF;
        rightSample = 32'h7FFF_FFFF;
        wait_for(2, 8'h00, 4400);
        check(detectedModeFlag, 1);
        leftSample = 32'h0;
        rightSample = 32'h0;
        fullscaleAutoMute = 1'b0;
        volumeBypass = 1'b1;
        softMuteBit = 1'b1;
        strobes(20);
        check(rampLevel, 6);
        #50 volumeBypass = 1'b0;
        strobes(2);
        check(rampLevel, 8'h04);
        wait_for(2, 8'h00, 200);
        softMuteBit = 1'b0;
        wait_for(2, 8'h06, 200);
        softMutePin = 1'b1;
        strobes(3);
        check(32'(rampLevel != 8'h00), 1);
        softMutePin = 1'b0;
        wait_for(2, 8'h06, 200);
        run = 1'b1;
        dsd = 1'b0;
        wait_for(0, 8'h00, 600);
        softResetRelease = 1'b1;
        powerEnableBits = 2'h3;
        leftSample = 32'h1;
        rightSample = 32'h1;
        wait_for(3, 8'h00, 40);
        check(analogFloat, 0);
        leftSample = 32'h0;
        strobes(14);
        check(zeroDetectOutputs, 2'h0);
        strobes(4);
        check(zeroDetectOutputs, 2'h1);
        rightSample = 32'h0;
        wait_for(3, 8'h01, 400);
        check(zeroDetectOutputs, 2'h3);
        leftSample = 32'h5;
        strobes(1);
        check(outValid, 1);
        check(leftOut, 0);
        @(posedge clk);
        #2 check(zeroDetectOutputs, 2'h2);
        check(outValid, 0);
        strobes(17);
        check(leftOut, 0);
        strobes(1);
        check(leftOut, 32'h5);
        check(rightOut, 0);
        conclude();
    end
endmodule : test_mode_detect_mute
`default_nettype wire

// ==== wck_bck_detector.sv ====
// bit-clock domain half of the mode detector: counts bit-clock edges
// per word-clock cycle and holds the detected mode on the bit clock only
`timescale 1ns/1ns
`default_nettype none

module wck_bck_detector
    import mode_detect_pkg::*;
(
    input  wire logic bitClock,     // bit clock from the source
    input  wire logic reset_n,      // core reset, resynchronised here
    input  wire logic wordClockIn,  // word clock pin
    input  wire logic detectEnable, // core-domain detection enable level
    output logic      modeDsd       // 1 = one-bit stream mode
);

    typedef struct packed {
        logic [1:0] rstSync;
        logic [2:0] wckSync;
        logic [1:0] enSync;
        logic [8:0] edgeCount;
        logic [1:0] shortRuns;
        logic       dsd;
    } det_t;

    det_t r;
    det_t n;
    logic wckRise;

    assign wckRise = r.wckSync[1] & ~r.wckSync[2];
    assign modeDsd = r.dsd;

    always_comb begin
        n = r;
        n.rstSync = {r.rstSync[0], reset_n};
        n.wckSync = {r.wckSync[1:0], wordClockIn};
        n.enSync  = {r.enSync[0], detectEnable};
        // counter clears on each word-clock rise and stops at limit+1
        if (wckRise) begin
            n.edgeCount = 9'h000;
        end else if (r.edgeCount < WCK_EDGE_SAT) begin
            n.edgeCount = 9'(r.edgeCount + 9'h001);
        end
        if (!r.enSync[1]) begin
            n.shortRuns = 2'h0;
        end else if (!wckRise && r.edgeCount == WCK_EDGE_LIMIT) begin
            // a held-low word clock still overflows here
            n.dsd       = 1'b1;
            n.shortRuns = 2'h0;
        end else if (wckRise) begin
            if (r.edgeCount <= WCK_EDGE_LIMIT) begin
                n.shortRuns = (r.shortRuns == EXF_SHORT_RUNS) ?
                              r.shortRuns : 2'(r.shortRuns + 2'h1);
                if (2'(r.shortRuns + 2'h1) >= EXF_SHORT_RUNS) begin
                    n.dsd = 1'b0;
                end
            end else begin
                n.shortRuns = 2'h0;
            end
        end
        // a stopped bit clock simply freezes all of this state
        if (!r.rstSync[1]) begin
            n.wckSync   = 3'h0;
            n.enSync    = 2'h0;
            n.edgeCount = 9'h000;
            n.shortRuns = 2'h0;
            n.dsd       = MODE_RESET;
        end
    end

    always_ff @(posedge bitClock) begin
        r <= n;
    end

    // core reset covers the first edges, before the local copy has settled
    a_dsd_on_overflow: assert property (
        @(posedge bitClock) disable iff (!reset_n || !r.rstSync[1])
        (r.enSync[1] && !wckRise && r.edgeCount == WCK_EDGE_LIMIT)
        |=> r.dsd)
        else $error("no stream mode after edge count overflow");

    a_exf_two_short: assert property (
        @(posedge bitClock) disable iff (!reset_n || !r.rstSync[1])
        (r.enSync[1] && wckRise && r.edgeCount <= WCK_EDGE_LIMIT
         && r.shortRuns == 2'h1)
        |=> !r.dsd)
        else $error("word mode not taken after two short cycles");

    a_single_short: assert property (
        @(posedge bitClock) disable iff (!reset_n || !r.rstSync[1])
        (r.enSync[1] && wckRise && r.edgeCount <= WCK_EDGE_LIMIT
         && r.shortRuns == 2'h0 && r.dsd)
        |=> r.dsd)
        else $error("left stream mode after one short cycle");

    a_count_saturates: assert property (
        @(posedge bitClock) disable iff (!reset_n || !r.rstSync[1])
        r.edgeCount <= WCK_EDGE_SAT)
        else $error("edge counter passed its saturation value");

    a_mode_hold_off: assert property (
        @(posedge bitClock) disable iff (!reset_n || !r.rstSync[1])
        !r.enSync[1] |=> $stable(r.dsd))
        else $error("mode changed while detection disabled");

endmodule : wck_bck_detector

`default_nettype wire
